// ==== dv/pru_src_model.sv ====
`timescale 1ns/1ps
module pru_src_model (
   input wire logic clock, // clock
   input wire logic rst_b, // reset
   input wire logic slow, // extra idle cycle per beat
   input wire logic in_ready, // beat taken
   output logic in_valid, // beat valid
   output logic [127:0] in_data // beat lanes
);
   logic [127:0] beats[$];
   logic hold_reg;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         in_valid <= 1'b0;
         in_data <= '0;
         hold_reg <= 1'b0;
      end else if (in_valid && in_ready) begin
         void'(beats.pop_front());
         in_valid <= 1'b0;
         // released lanes flip so stale data never looks valid
         in_data <= ~in_data;
         hold_reg <= slow;
      end else if (hold_reg) begin
         hold_reg <= 1'b0;
      end else if (!in_valid && beats.size() > 0) begin
         in_valid <= 1'b1;
         in_data <= beats[0];
      end
   end
endmodule

// ==== dv/pru_tb.sv ====
`timescale 1ns/1ps
module testbench;
   import pru_pkg::*;
   typedef struct packed {logic [11:0] c; logic [127:0] d; logic [67:0] e;} pru_row_t;
   localparam logic [16:0] ONE = 17'h10000;
   localparam logic [16:0] H = 17'h08080;
   localparam logic [16:0] Z = 17'h0;
   localparam logic [67:0] RCOL = 68'h1_2345_6789_abcd_ef01;
   localparam logic [16:0] RDEP = 17'h0abcd;
   localparam logic [31:0] RTEX = 32'h1234_5678;
   logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic prim = 1'b0, frag_ready = 1'b0, slow = 1'b0, err;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, in_valid, in_ready, frag_valid, frag_is_depth;
   logic [127:0] in_data;
   logic [15:0] frag_x, frag_y;
   logic [67:0] frag_color;
   logic [16:0] frag_depth;
   logic [31:0] frag_tex;
   int num_errors = 0, check_count = 0;
   pru_row_t rows[9];
   always #12.5 clock = ~clock;
   pru_top dut (.*, .primitive_active(prim), .raster_depth(RDEP), .raster_color(RCOL),
      .raster_tex(RTEX));
   pru_src_model src (.*);
   function automatic logic [67:0] col(input logic [16:0] r, g, b, a);
      return {a, b, g, r};
   endfunction
   task automatic chk(input logic [127:0] got, exp, input string m);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic frag(input logic [15:0] x, y, input logic [67:0] c, input logic [16:0] d,
                       input logic isd);
      do @(negedge clock); while (frag_valid !== 1'b1);
      chk(frag_color, c, "colour");
      chk({frag_x, frag_y, frag_is_depth, frag_depth, frag_tex}, {x, y, isd, d, RTEX},
          "place or depth");
      @(posedge clock);
      frag_ready <= 1'b1;
      @(posedge clock);
      frag_ready <= 1'b0;
   endtask
   task automatic idle();
      do apb(1'b0, STAT_OFS, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic run1(input logic [11:0] c, input logic [127:0] d, input logic [67:0] e);
      wr(CTRL_OFS, {20'h0, c});
      wr(CMD_OFS, 32'h1);
      src.beats.push_back(d);
      frag(16'h0010, 16'h0020, e, RDEP, 1'b0);
      idle();
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      $display("BAD %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      logic [15:0] ce[9] = '{16'h0072, 16'h0072, 16'h00b4, 16'h0874, 16'h0274, 16'h2078,
                             16'h0018, 16'h4210, 16'h0078};
      logic [15:0] din[4] = '{16'hffff, 16'h0, 16'h8000, 16'hc000};
      logic [16:0] dex[4] = '{ONE, Z, 17'h08000, 17'h0e000};
      rows[0] = '{12'h7, {32'hff, 32'h80, 32'h0, 32'hff}, col(ONE, Z, H, ONE)};
      rows[1] = '{12'h17, {32'h7f, 32'h0, 32'h80, 32'h7f}, col(ONE, Z, Z, ONE)};
      rows[2] = '{12'h33, {4{32'hffff}}, col(ONE, Z, Z, ONE)};
      rows[3] = '{12'h44, {4{32'h7fff}}, col(Z, ONE, Z, ONE)};
      rows[4] = '{12'h55, {4{32'hffffffff}}, col(Z, Z, ONE, ONE)};
      rows[5] = '{12'h66, {4{32'h7fffffff}}, col(Z, Z, Z, ONE)};
      rows[6] = '{12'h78, {64'h0, 32'h3f000000, 32'h3f800000}, col(ONE, 17'h08000, Z, ONE)};
      rows[7] = '{12'h9, {32'h0, 32'hff, 32'hff, 32'h80}, col(H, H, H, ONE)};
      rows[8] = '{12'ha, {32'hff, 32'hff, 32'h0, 32'h80}, col(H, H, H, Z)};
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      apb(1'b0, ZOOM_OFS, 32'h0);
      chk(q, 32'h0101, "zoom reset value");
      apb(1'b0, 8'h50, 32'h0);
      chk({err, q}, 33'h100000000, "unmapped read");
      wr(RPOS_OFS, 32'h00200010);
      wr(SIZE_OFS, 32'h00010001);
      foreach (rows[i]) run1(rows[i].c, rows[i].d, rows[i].e);
      for (int i = 0; i < 9; i++) begin
         wr(CTRL_OFS, 32'(ce[i][15:4]));
         wr(SIZE_OFS, i == 0 ? 32'h1ffff : i == 1 ? 32'hffff0001 : 32'h10001);
         prim <= (i == 8);
         wr(CMD_OFS, 32'h1);
         prim <= 1'b0;
         apb(1'b0, STAT_OFS, 32'h0);
         chk(q, 32'(ce[i][3:0]), "error status");
         wr(STAT_OFS, 32'he);
      end
      slow <= 1'b1;
      wr(DMUL_OFS, 32'h18000);
      wr(DOFF_OFS, 32'hffffc000);
      wr(SIZE_OFS, 32'h00020002);
      wr(ZOOM_OFS, 32'h0102);
      wr(CTRL_OFS, 32'h32);
      wr(CMD_OFS, 32'h1);
      for (int n = 0; n < 4; n++) src.beats.push_back(128'(din[n]));
      for (int n = 0; n < 4; n++) begin
         for (int k = 0; k < 2; k++) begin
            frag(16'(16 + 2 * (n % 2) + k), 16'(32 + n / 2), RCOL, dex[n], 1'b1);
         end
      end
      idle();
      apb(1'b0, FCNT_OFS, 32'h0);
      chk(q, 32'h8, "fragment count");
      wr(SIZE_OFS, 32'h00010001);
      wr(ZOOM_OFS, 32'h0101);
      wr(CMUL_OFS, 32'h8000);
      wr(8'(COFF_OFS + 4), 32'h10000);
      wr(8'(COFF_OFS + 8), 32'hffffc000);
      run1(12'h7, rows[0].d, col(17'h08000, ONE, 17'h04080, ONE));
      for (int c = 0; c < 4; c++) begin
         wr(LADR_OFS, 32'(c << 8));
         for (int i = 0; i < 16; i++) wr(LDAT_OFS, 32'(c * 256 + i * 16));
      end
      run1(12'h107, rows[0].d, col(17'h080, 17'h1f0, 17'h240, 17'h3f0));
      give_verdict();
   end
endmodule

// ==== dv/pru_top_assertions.sv ====
`timescale 1ns/1ps
module pru_checker #(
   parameter int FRAC_W = 16,
   parameter int TEX_W = 32
) (
   input wire logic clock, // clock
   input wire logic rst_b, // reset
   input wire logic in_valid, // beat valid
   input wire logic in_ready, // beat taken
   input wire logic [FRAC_W:0] raster_depth, // raster z
   input wire logic [4*(FRAC_W+1)-1:0] raster_color, // raster rgba
   input wire logic [TEX_W-1:0] raster_tex, // raster tex
   input wire logic frag_valid, // fragment valid
   input wire logic frag_ready, // fragment taken
   input wire logic [15:0] frag_x, // column
   input wire logic [15:0] frag_y, // row
   input wire logic [4*(FRAC_W+1)-1:0] frag_color, // rgba
   input wire logic [FRAC_W:0] frag_depth, // depth
   input wire logic [TEX_W-1:0] frag_tex, // tex
   input wire logic frag_is_depth // depth pixel
);
   localparam logic [FRAC_W:0] ONE = {1'b1, {FRAC_W{1'b0}}};
   logic [FRAC_W:0] dep_reg;
   logic [4*(FRAC_W+1)-1:0] col_reg;
   logic [TEX_W-1:0] tex_reg;
   // raster state as it stood at the take edge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dep_reg <= '0;
         col_reg <= '0;
         tex_reg <= '0;
      end else if (in_valid && in_ready) begin
         dep_reg <= raster_depth;
         col_reg <= raster_color;
         tex_reg <= raster_tex;
      end
   end
   default clocking dcb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   AST_TEX_CARRIED: assert property (frag_valid |-> frag_tex == tex_reg)
      else $error("texture lost");
   AST_DEPTH_COLOR: assert property (frag_valid && frag_is_depth
      |-> frag_color == col_reg) else $error("colour lost");
   AST_COLOR_DEPTH: assert property (frag_valid && !frag_is_depth
      |-> frag_depth == dep_reg) else $error("depth lost");
   AST_DEPTH_CLAMP: assert property (frag_valid && frag_is_depth |-> frag_depth <= ONE)
      else $error("depth above one");
   AST_FRAG_HELD: assert property (frag_valid && !frag_ready |=> frag_valid
      && $stable({frag_x, frag_y, frag_color, frag_depth}))
      else $error("stall changed");
   AST_BEAT_WAITS: assert property (frag_valid |-> !in_ready)
      else $error("beat in stall");
   AST_READY_DROPS: assert property (in_valid && in_ready |=> !in_ready)
      else $error("beat twice");
   AST_QUIET_START: assert property ($rose(rst_b) |-> !frag_valid && !in_ready)
      else $error("early activity");
   CVR_DEPTH: cover property (frag_valid && frag_ready && frag_is_depth);
   CVR_COLOR: cover property (frag_valid && frag_ready && !frag_is_depth);
   CVR_STALL: cover property (frag_valid && !frag_ready);
endmodule

bind pru_top pru_checker #(.FRAC_W(FRAC_W), .TEX_W(TEX_W)) u_chk (.*);

// ==== verilog/pru_pkg.sv ====
package pru_pkg;
   // ****************
   // register map
   // ****************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] SIZE_OFS = 8'h0c;
   localparam logic [7:0] RPOS_OFS = 8'h10;
   localparam logic [7:0] ZOOM_OFS = 8'h14;
   localparam logic [7:0] DMUL_OFS = 8'h18;
   localparam logic [7:0] DOFF_OFS = 8'h1c;
   localparam logic [7:0] CMUL_OFS = 8'h20;
   localparam logic [7:0] COFF_OFS = 8'h30;
   localparam logic [7:0] LADR_OFS = 8'h40;
   localparam logic [7:0] LDAT_OFS = 8'h44;
   localparam logic [7:0] FCNT_OFS = 8'h48;

   // ****************
   // field positions
   // ****************
   localparam int CTRL_FMT_LSB = 0;
   localparam int CTRL_TYP_LSB = 4;
   localparam int CTRL_LUT_BIT = 8;
   localparam int CTRL_PAL_BIT = 9;
   localparam int CTRL_STN_BIT = 10;
   localparam int CMD_GO_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_VAL_BIT = 1;
   localparam int STAT_TOK_BIT = 2;
   localparam int STAT_OP_BIT = 3;
   localparam int LADR_CH_LSB = 8;

   // ****************
   // reset values
   // ****************
   localparam logic [3:0] FMT_RST = 4'h7;
   localparam logic [3:0] TYP_RST = 4'h0;
   localparam logic [7:0] ZOOM_RST = 8'h01;
   localparam int DEF_FRAC_W = 16;
   localparam int DEF_LUT_AW = 4;
   localparam int DEF_TEX_W = 32;

   // ****************
   // encodings
   // ****************
   typedef enum logic [3:0] {
      FMT_PALETTE = 4'h0,
      FMT_STENCIL = 4'h1,
      FMT_DEPTH = 4'h2,
      FMT_RED = 4'h3,
      FMT_GREEN = 4'h4,
      FMT_BLUE = 4'h5,
      FMT_OPACITY = 4'h6,
      FMT_FOUR = 4'h7,
      FMT_THREE = 4'h8,
      FMT_GREY = 4'h9,
      FMT_GREYA = 4'ha
   } pru_fmt_t;

   typedef enum logic [3:0] {
      TYP_U8 = 4'h0,
      TYP_S8 = 4'h1,
      TYP_BITS = 4'h2,
      TYP_U16 = 4'h3,
      TYP_S16 = 4'h4,
      TYP_U32 = 4'h5,
      TYP_S32 = 4'h6,
      TYP_F32 = 4'h7
   } pru_typ_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } pru_state_t;
endpackage

// ==== verilog/pru_top.sv ====
// Behaviour
// [R01] signed integers scale linearly, max positive to 1.0, max negative to -1.0
// [R02] unsigned integers scale linearly, max to 1.0, zero to 0.0
// [R03] depth times multiplier plus offset, clamped to zero..one
// [R04] depth fragments carry raster colour, texture; placed column-modulo, row-quotient
// [R05] four-channel pixel lanes are red, green, blue, alpha in order
// [R06] each colour channel times its multiplier plus its offset, clamped zero..one
// [R07] lookup enabled: channel scaled by table size, replaced by table entry
// [R08] colour fragments carry raster depth, texture; same placement formula
// [R09] single colour channel: others 0.0, alpha 1.0, then four-channel path
// [R10] opacity-only: red, green, blue 0.0, then four-channel path
// [R11] three-channel red, green, blue gets alpha 1.0
// [R12] grey copied to red, green, blue; alpha 1.0
// [R13] grey then alpha; grey into red, green, blue, alpha converted
// [R14] component types: u8, s8, u16, s16, u32, s32, f32
// [R15] packed-bit type holds single-bit pixels in unsigned bytes
// [R16] non-unit zoom fills every pixel centre of the zoomed rectangle
// [R17] negative width or height raises bad_value_error, command rejected
// [R18] unknown format or type code raises bad_token_error
// [R19] colour format in palette mode raises bad_operation_error
// [R20] stencil_format without stencil buffer raises bad_operation_error
// [R21] command inside an open primitive raises bad_operation_error, ignored
// [R22] fixed fraction width at build time; row-major, one pixel per beat
`timescale 1ns/1ps
module pru_top #(
   parameter int FRAC_W = pru_pkg::DEF_FRAC_W,
   parameter int LUT_AW = pru_pkg::DEF_LUT_AW,
   parameter int TEX_W = pru_pkg::DEF_TEX_W
) (
   input wire logic clock, // 40 MHz
   input wire logic rst_b, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // unmapped access
   input wire logic in_valid, // pixel beat valid
   output logic in_ready, // pixel beat taken
   input wire logic [127:0] in_data, // four 32-bit component lanes
   input wire logic primitive_active, // between open and close
   input wire logic [FRAC_W:0] raster_depth, // raster z
   input wire logic [4*(FRAC_W+1)-1:0] raster_color, // raster rgba, red low
   input wire logic [TEX_W-1:0] raster_tex, // raster texture coords
   output logic frag_valid, // fragment valid
   input wire logic frag_ready, // fragment taken
   output logic [15:0] frag_x, // window column
   output logic [15:0] frag_y, // window row
   output logic [4*(FRAC_W+1)-1:0] frag_color, // rgba, red low
   output logic [FRAC_W:0] frag_depth, // depth
   output logic [TEX_W-1:0] frag_tex, // texture coords
   output logic frag_is_depth // fragment from depth pixel
);
   import pru_pkg::*;

   localparam int CW = FRAC_W + 2;
   localparam int VW = FRAC_W + 1;
   localparam int LN = 1 << LUT_AW;
   // 1.0 in the internal fixed format (see [R22])
   localparam logic signed [CW-1:0] ONE = {2'b01, {FRAC_W{1'b0}}};
   localparam logic [63:0] MAXM = (64'h1 << (CW - 1)) - 64'h1;

   // ****************
   // conversion helpers
   // ****************
   function automatic logic signed [CW-1:0] norm_int(input logic [31:0] w, input int n,
                                                     input logic sgn);
      logic [31:0] x;
      logic [32:0] top;
      logic [CW-1:0] f;
      logic neg;
      int nb;
      neg = sgn & w[n-1];
      nb = sgn ? n - 1 : n;
      x = neg ? (~w + 32'h1) : w;
      x = x & ((n == 32) ? 32'hffffffff : ((32'h1 << n) - 32'h1));
      top = (33'h1 << nb) - 33'h1;
      f = '0;
      // full scale is caught by the compare and set to exactly 1.0; bit replication fills smaller values (see [R01] [R02])
      if ({1'b0, x} >= top) begin
         f = ONE;
      end else begin
         for (int i = 0; i < FRAC_W; i++) begin
            f[FRAC_W-1-i] = x[nb-1-(i % nb)];
         end
      end
      return neg ? -$signed(f) : $signed(f);
   endfunction

   function automatic logic signed [CW-1:0] f2fix(input logic [31:0] f);
      logic [63:0] mag;
      logic [CW-1:0] r;
      int sh;
      sh = int'(f[30:23]) - 150 + FRAC_W;
      mag = 64'h0;
      // denormals flush to zero; inf and nan saturate
      if (f[30:23] != 8'h00) begin
         if (sh > 39) begin
            mag = '1;
         end else if (sh >= 0) begin
            mag = {40'h0, 1'b1, f[22:0]} << sh;
         end else if (sh > -24) begin
            mag = {40'h0, 1'b1, f[22:0]} >> (-sh);
         end
      end
      if (mag > MAXM) begin
         mag = MAXM;
      end
      r = mag[CW-1:0];
      return f[31] ? -$signed(r) : $signed(r);
   endfunction

   function automatic logic [VW-1:0] bias_clamp(input logic signed [CW-1:0] m,
                                                input logic signed [CW-1:0] o,
                                                input logic signed [CW-1:0] x);
      logic signed [2*CW-1:0] p;
      logic signed [2*CW-1:0] s;
      logic [VW-1:0] r;
      p = m * x;
      s = (p >>> FRAC_W) + (2*CW)'(o);
      if (s < 0) begin
         r = '0;
      end else if (s > (2*CW)'(ONE)) begin
         r = ONE[VW-1:0];
      end else begin
         r = s[VW-1:0];
      end
      return r;
   endfunction

   // ****************
   // registers
   // ****************
   pru_state_t state_reg;
   logic [3:0] fmt_reg, typ_reg;
   logic lut_en_reg, pal_reg, stn_reg;
   logic signed [15:0] width_reg, height_reg, rx_reg, ry_reg;
   logic [7:0] zx_reg, zy_reg;
   logic signed [CW-1:0] dmul_reg, doff_reg;
   logic signed [CW-1:0] cmul_reg [4];
   logic signed [CW-1:0] coff_reg [4];
   logic [LUT_AW-1:0] lidx_reg;
   logic [1:0] lch_reg;
   logic [VW-1:0] lut_reg [4][LN];
   logic err_val_reg, err_tok_reg, err_op_reg;
   logic [31:0] fcnt_reg;
   logic pix_reg, last_reg;
   logic [15:0] col_reg, row_reg, base_x_reg, x_reg, y_reg;
   logic [7:0] sx_reg, sy_reg;
   logic [4*VW-1:0] color_reg;
   logic [VW-1:0] depth_reg;
   logic [TEX_W-1:0] tex_reg;
   logic is_depth_reg;

   // ****************
   // apb slave
   // ****************
   logic hit, wr, busy;
   assign busy = (state_reg == ST_RUN);
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite & hit;
   assign pslverr = psel & penable & ~hit;

   always_comb begin
      hit = (paddr[1:0] == 2'b00);
      prdata = 32'h0;
      case (paddr)
         CTRL_OFS: prdata = {21'h0, stn_reg, pal_reg, lut_en_reg, typ_reg, fmt_reg};
         CMD_OFS: prdata = 32'h0;
         STAT_OFS: prdata = {28'h0, err_op_reg, err_tok_reg, err_val_reg, busy};
         SIZE_OFS: prdata = {height_reg, width_reg};
         RPOS_OFS: prdata = {ry_reg, rx_reg};
         ZOOM_OFS: prdata = {16'h0, zy_reg, zx_reg};
         DMUL_OFS: prdata = 32'(dmul_reg);
         DOFF_OFS: prdata = 32'(doff_reg);
         LADR_OFS: begin
            prdata[LUT_AW-1:0] = lidx_reg;
            prdata[LADR_CH_LSB+:2] = lch_reg;
         end
         LDAT_OFS: prdata[VW-1:0] = lut_reg[lch_reg][lidx_reg];
         FCNT_OFS: prdata = fcnt_reg;
         default: begin
            if (paddr[7:4] == CMUL_OFS[7:4]) begin
               prdata = 32'(cmul_reg[paddr[3:2]]);
            end else if (paddr[7:4] == COFF_OFS[7:4]) begin
               prdata = 32'(coff_reg[paddr[3:2]]);
            end else begin
               hit = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fmt_reg <= FMT_RST;
         typ_reg <= TYP_RST;
         {lut_en_reg, pal_reg, stn_reg} <= 3'b000;
         width_reg <= '0;
         height_reg <= '0;
         rx_reg <= '0;
         ry_reg <= '0;
         zx_reg <= ZOOM_RST;
         zy_reg <= ZOOM_RST;
         dmul_reg <= ONE;
         doff_reg <= '0;
         for (int k = 0; k < 4; k++) begin
            cmul_reg[k] <= ONE;
            coff_reg[k] <= '0;
         end
      end else if (wr) begin
         case (paddr)
            CTRL_OFS: begin
               fmt_reg <= pwdata[CTRL_FMT_LSB+:4];
               typ_reg <= pwdata[CTRL_TYP_LSB+:4];
               lut_en_reg <= pwdata[CTRL_LUT_BIT];
               pal_reg <= pwdata[CTRL_PAL_BIT];
               stn_reg <= pwdata[CTRL_STN_BIT];
            end
            SIZE_OFS: {height_reg, width_reg} <= pwdata;
            RPOS_OFS: {ry_reg, rx_reg} <= pwdata;
            ZOOM_OFS: {zy_reg, zx_reg} <= pwdata[15:0];
            DMUL_OFS: dmul_reg <= pwdata[CW-1:0];
            DOFF_OFS: doff_reg <= pwdata[CW-1:0];
            default: begin
               if (paddr[7:4] == CMUL_OFS[7:4]) cmul_reg[paddr[3:2]] <= pwdata[CW-1:0];
               if (paddr[7:4] == COFF_OFS[7:4]) coff_reg[paddr[3:2]] <= pwdata[CW-1:0];
            end
         endcase
      end
   end

   // table port: index steps after each data write for burst loading
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lidx_reg <= '0;
         lch_reg <= 2'b00;
         for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < LN; j++) begin
               lut_reg[k][j] <= '0;
            end
         end
      end else if (wr && paddr == LADR_OFS) begin
         lidx_reg <= pwdata[LUT_AW-1:0];
         lch_reg <= pwdata[LADR_CH_LSB+:2];
      end else if (wr && paddr == LDAT_OFS) begin
         lut_reg[lch_reg][lidx_reg] <= pwdata[VW-1:0];
         lidx_reg <= lidx_reg + 1'b1;
      end
   end

   // ****************
   // command check
   // ****************
   logic start, colour_fmt, e_prim, e_val, e_tok, e_op, go;
   assign start = wr && paddr == CMD_OFS && pwdata[CMD_GO_BIT] && !busy;
   assign colour_fmt = (fmt_reg >= FMT_RED) && (fmt_reg <= FMT_GREYA);
   assign e_prim = primitive_active; // see [R21]
   assign e_val = width_reg[15] | height_reg[15]; // see [R17]
   // packed bits only go with index formats, see [R15] [R18]
   assign e_tok = (fmt_reg > FMT_GREYA) | (typ_reg > TYP_F32)
                | (typ_reg == TYP_BITS && fmt_reg > FMT_STENCIL);
   assign e_op = (colour_fmt & pal_reg) // see [R19]
               | (fmt_reg == FMT_STENCIL && !stn_reg); // see [R20]
   // palette and stencil rectangles are accepted but produce no fragments
   assign go = start && !e_prim && !e_val && !e_tok && !e_op
             && (colour_fmt || fmt_reg == FMT_DEPTH)
             && width_reg != 16'sd0 && height_reg != 16'sd0;

   logic clr_val, clr_tok, clr_op;
   assign clr_val = wr && paddr == STAT_OFS && pwdata[STAT_VAL_BIT];
   assign clr_tok = wr && paddr == STAT_OFS && pwdata[STAT_TOK_BIT];
   assign clr_op = wr && paddr == STAT_OFS && pwdata[STAT_OP_BIT];

   // one error per command; a new error wins over a same-cycle clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         {err_val_reg, err_tok_reg, err_op_reg} <= 3'b000;
      end else begin
         err_op_reg <= (start & (e_prim | (~e_val & ~e_tok & e_op)))
                     | (err_op_reg & ~clr_op); // see [R19] [R20] [R21]
         err_val_reg <= (start & ~e_prim & e_val) | (err_val_reg & ~clr_val); // see [R17]
         err_tok_reg <= (start & ~e_prim & ~e_val & e_tok)
                      | (err_tok_reg & ~clr_tok); // see [R18]
      end
   end

   // ****************
   // pixel datapath
   // ****************
   int nbits;
   logic sgn, flt;
   logic signed [CW-1:0] c [4];
   logic signed [CW-1:0] e [4];
   logic [VW-1:0] v, cf;
   logic [LUT_AW:0] ix;
   logic [4*VW-1:0] pix_color;
   logic [VW-1:0] dval;

   always_comb begin
      flt = (typ_reg == TYP_F32); // see [R14]
      sgn = (typ_reg == TYP_S8) | (typ_reg == TYP_S16) | (typ_reg == TYP_S32);
      case (typ_reg)
         TYP_U16, TYP_S16: nbits = 16;
         TYP_U32, TYP_S32: nbits = 32;
         default: nbits = 8;
      endcase
      // lane k is component k in arrival order, see [R05]
      for (int k = 0; k < 4; k++) begin
         c[k] = flt ? f2fix(in_data[32*k+:32]) : norm_int(in_data[32*k+:32], nbits, sgn);
      end
      e = c;
      case (fmt_reg)
         FMT_RED: e = '{c[0], '0, '0, ONE}; // see [R09]
         FMT_GREEN: e = '{'0, c[0], '0, ONE}; // see [R09]
         FMT_BLUE: e = '{'0, '0, c[0], ONE}; // see [R09]
         FMT_OPACITY: e = '{'0, '0, '0, c[0]}; // see [R10]
         FMT_THREE: e = '{c[0], c[1], c[2], ONE}; // see [R11]
         FMT_GREY: e = '{c[0], c[0], c[0], ONE}; // see [R12]
         FMT_GREYA: e = '{c[0], c[0], c[0], c[1]}; // see [R13]
         default: e = c;
      endcase
      pix_color = '0;
      for (int k = 0; k < 4; k++) begin
         v = bias_clamp(cmul_reg[k], coff_reg[k], e[k]); // see [R06]
         // full-scale 1.0 would index one past the end, so it folds to the last entry
         ix = v[FRAC_W-:LUT_AW+1];
         cf = lut_reg[k][ix[LUT_AW] ? {LUT_AW{1'b1}} : ix[LUT_AW-1:0]];
         pix_color[k*VW+:VW] = lut_en_reg ? cf : v; // see [R07]
      end
      dval = bias_clamp(dmul_reg, doff_reg, c[0]); // see [R03]
   end

   // ****************
   // fragment stage
   // ****************
   logic take, fire, end_x, end_y, zoom_zero, last_pix;
   assign in_ready = busy & ~pix_reg & ~last_reg; // see [R22]
   assign take = in_valid & in_ready;
   assign fire = pix_reg & frag_ready;
   assign end_x = (sx_reg == zx_reg - 8'h01);
   assign end_y = (sy_reg == zy_reg - 8'h01);
   assign zoom_zero = (zx_reg == 8'h00) | (zy_reg == 8'h00);
   assign last_pix = (col_reg == 16'(width_reg - 16'sd1))
                   && (row_reg == 16'(height_reg - 16'sd1));

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         last_reg <= 1'b0;
         col_reg <= '0;
         row_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               col_reg <= '0;
               row_reg <= '0;
               if (go) state_reg <= ST_RUN;
            end
            ST_RUN: begin
               // row-major walk, see [R04] [R08] [R22]
               if (take) begin
                  last_reg <= last_pix;
                  if (col_reg == 16'(width_reg - 16'sd1)) begin
                     col_reg <= '0;
                     row_reg <= row_reg + 16'h0001;
                  end else begin
                     col_reg <= col_reg + 16'h0001;
                  end
               end
               if (last_reg && !pix_reg) begin
                  last_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pix_reg <= 1'b0;
         {base_x_reg, x_reg, y_reg} <= '0;
         {sx_reg, sy_reg} <= '0;
      end else if (take) begin
         // zoom spans columns rx+zx*n .. rx+zx*(n+1)-1, see [R16] [R04] [R08]
         pix_reg <= ~zoom_zero;
         base_x_reg <= rx_reg + 16'(zx_reg * col_reg);
         x_reg <= rx_reg + 16'(zx_reg * col_reg);
         y_reg <= ry_reg + 16'(zy_reg * row_reg);
         sx_reg <= 8'h00;
         sy_reg <= 8'h00;
      end else if (fire) begin
         if (!end_x) begin
            sx_reg <= sx_reg + 8'h01; // see [R16]
            x_reg <= x_reg + 16'h0001;
         end else begin
            sx_reg <= 8'h00;
            x_reg <= base_x_reg;
            if (end_y) begin
               pix_reg <= 1'b0;
            end else begin
               sy_reg <= sy_reg + 8'h01; // see [R16]
               y_reg <= y_reg + 16'h0001;
            end
         end
      end
   end

   // depth pixels borrow raster colour, colour pixels raster depth
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         color_reg <= '0;
         depth_reg <= '0;
         tex_reg <= '0;
         is_depth_reg <= 1'b0;
      end else if (take) begin
         is_depth_reg <= (fmt_reg == FMT_DEPTH);
         tex_reg <= raster_tex; // see [R04] [R08]
         color_reg <= (fmt_reg == FMT_DEPTH) ? raster_color : pix_color; // see [R04]
         depth_reg <= (fmt_reg == FMT_DEPTH) ? dval : raster_depth; // see [R08]
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fcnt_reg <= 32'h0;
      end else if (go) begin
         fcnt_reg <= 32'h0;
      end else if (fire) begin
         fcnt_reg <= fcnt_reg + 32'h1;
      end
   end

   assign frag_valid = pix_reg;
   assign frag_x = x_reg;
   assign frag_y = y_reg;
   assign frag_color = color_reg;
   assign frag_depth = depth_reg;
   assign frag_tex = tex_reg;
   assign frag_is_depth = is_depth_reg;
endmodule
